// [verilog/ciar_top.sv]
// interlace, row address, cursor, start address and light pen logic
`timescale 1ns/1ps
module ciar_top
	import ciar_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [ciar_pkg::IDX_W-1:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [ciar_pkg::DATA_W-1:0] REG_WDATA,
	output logic [ciar_pkg::DATA_W-1:0] REG_RDATA,
	input wire logic CHAR_TICK,
	input wire logic DISP_ACTIVE,
	input wire logic LINE_END,
	input wire logic HALF_LINE,
	input wire logic FRAME_START,
	input wire logic VSYNC_REQ,
	input wire logic PEN_STROBE_IN,
	output logic [ciar_pkg::ADDR_W-1:0] REFRESH_ADDRESS,
	output logic [ciar_pkg::ROW_W-1:0] ROW_ADDRESS,
	output logic VERTICAL_SYNC,
	output logic CURSOR_OUT,
	output logic FIELD_ODD
);
	import ciar_pkg::*;

	logic [MODE_W-1:0] interlace_mode_select_reg;
	logic [ROW_W-1:0] max_scan_line_reg;
	logic [CUR_FIRST_W-1:0] cursor_first_line_and_blink_reg;
	logic [ROW_W-1:0] cursor_last_line_reg;
	logic [HIGH_W-1:0] cursor_position_high_reg;
	logic [DATA_W-1:0] cursor_position_low_reg;
	logic [HIGH_W-1:0] display_start_high_reg;
	logic [DATA_W-1:0] display_start_low_reg;
	logic [ADDR_W-1:0] row_base_reg;
	logic field_odd_next;
	logic row_last;
	logic [ROW_W-1:0] row_first;
	logic [ROW_W-1:0] row_step;
	logic [ADDR_W-1:0] start_addr;
	logic [ADDR_W-1:0] cursor_addr;
	logic [ADDR_W-1:0] pen_addr;
	logic [FIELD_CNT_W-1:0] field_count;
	ciar_scan_t scan_mode;
	ciar_cur_t cur_mode;
	ciar_vs_t vs_reg;
	ciar_vs_t vs_next;
	logic vsync_req_d_reg;
	logic interlaced;
	logic video_il;
	logic blink_on;
	logic cursor_span;
	logic cursor_hit;

	// last scan line of a character row; in sync and video mode each
	// field visits every second line, so the row ends on max or one short of max
	function automatic logic is_last_line(input logic [ROW_W-1:0] row,
			input logic [ROW_W-1:0] max_line, input logic video);
		logic [ROW_W:0] ahead;
		ahead = {1'b0, row} + {1'b0, ROW_STEP_TWO};
		if (video) begin
			is_last_line = ahead > {1'b0, max_line};
		end else begin
			is_last_line = row == max_line;
		end
	endfunction

	// line lies between first and last inclusive
	function automatic logic in_span(input logic [ROW_W-1:0] row,
			input logic [ROW_W-1:0] first, input logic [ROW_W-1:0] last);
		in_span = (row >= first) && (row <= last);
	endfunction

	// mode decode; the unlisted code 10 behaves as normal scanning
	assign scan_mode = ciar_scan_t'(interlace_mode_select_reg);
	assign interlaced = (scan_mode == SCAN_ISYNC) ||
		(scan_mode == SCAN_IVIDEO);
	assign video_il = scan_mode == SCAN_IVIDEO;
	assign cur_mode = ciar_cur_t'(cursor_first_line_and_blink_reg[
		CUR_MODE_LSB +: CUR_MODE_W]);
	assign start_addr = {display_start_high_reg, display_start_low_reg};
	assign cursor_addr = {cursor_position_high_reg,
		cursor_position_low_reg};

	// register writes from the processor port
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			interlace_mode_select_reg <= RST_MODE;
			max_scan_line_reg <= RST_ROW;
			cursor_first_line_and_blink_reg <= RST_CUR_FIRST;
			cursor_last_line_reg <= RST_ROW;
			display_start_high_reg <= RST_ADDR[ADDR_W-1 -: HIGH_W];
			display_start_low_reg <= RST_DATA;
			cursor_position_high_reg <= RST_ADDR[ADDR_W-1 -: HIGH_W];
			cursor_position_low_reg <= RST_DATA;
		end else if (REG_WR) begin
			unique case (REG_ADDR)
				IDX_INTERLACE: begin
					interlace_mode_select_reg <=
						REG_WDATA[MODE_LSB +: MODE_W];
				end
				IDX_MAX_SCAN: begin
					max_scan_line_reg <= REG_WDATA[ROW_W-1:0];
				end
				IDX_CUR_FIRST: begin
					cursor_first_line_and_blink_reg <=
						REG_WDATA[CUR_FIRST_W-1:0];
				end
				IDX_CUR_LAST: begin
					cursor_last_line_reg <= REG_WDATA[ROW_W-1:0];
				end
				IDX_START_HI: begin
					display_start_high_reg <= REG_WDATA[HIGH_W-1:0];
				end
				IDX_START_LO: begin
					display_start_low_reg <= REG_WDATA;
				end
				IDX_CUR_POS_HI: begin
					cursor_position_high_reg <= REG_WDATA[HIGH_W-1:0];
				end
				IDX_CUR_POS_LO: begin
					cursor_position_low_reg <= REG_WDATA;
				end
				default: begin
				end
			endcase
		end
	end

	// read data is registered; write-only and unmapped indexes read zero
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			REG_RDATA <= RST_DATA;
		end else if (REG_RD) begin
			unique case (REG_ADDR)
				IDX_CUR_POS_HI: begin
					REG_RDATA <= {2'h0, cursor_position_high_reg};
				end
				IDX_CUR_POS_LO: begin
					REG_RDATA <= cursor_position_low_reg;
				end
				IDX_PEN_HI: begin
					REG_RDATA <= {2'h0, pen_addr[ADDR_W-1 -: HIGH_W]};
				end
				IDX_PEN_LO: begin
					REG_RDATA <= pen_addr[DATA_W-1:0];
				end
				default: begin
					REG_RDATA <= RST_DATA;
				end
			endcase
		end
	end

	// field flips each frame only when interlaced; normal mode keeps one
	assign field_odd_next = interlaced ? !FIELD_ODD : 1'b0;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			FIELD_ODD <= 1'b0;
		end else if (FRAME_START) begin
			FIELD_ODD <= field_odd_next;
		end
	end

	// sync and video mode starts the odd field on line one, otherwise
	// both fields walk the same lines with the same addresses
	assign row_first = (video_il && field_odd_next) ? ROW_STEP_ONE :
		RST_ROW;
	assign row_step = video_il ? ROW_STEP_TWO : ROW_STEP_ONE;
	assign row_last = is_last_line(ROW_ADDRESS, max_scan_line_reg,
		video_il);

	// row address counter, one step per scan line
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ROW_ADDRESS <= RST_ROW;
		end else if (FRAME_START) begin
			ROW_ADDRESS <= row_first;
		end else if (LINE_END) begin
			if (row_last) begin
				ROW_ADDRESS <= video_il && FIELD_ODD ? ROW_STEP_ONE :
					RST_ROW;
			end else begin
				ROW_ADDRESS <= ROW_ADDRESS + row_step;
			end
		end
	end

	// refresh address: counts displayed characters; each scan line
	// restarts from the row base, and the row base moves on only when
	// the character row ends, so all lines of a row share addresses
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			REFRESH_ADDRESS <= RST_ADDR;
			row_base_reg <= RST_ADDR;
		end else if (FRAME_START) begin
			REFRESH_ADDRESS <= start_addr;
			row_base_reg <= start_addr;
		end else if (LINE_END) begin
			if (row_last) begin
				row_base_reg <= REFRESH_ADDRESS;
			end else begin
				REFRESH_ADDRESS <= row_base_reg;
			end
		end else if (CHAR_TICK && DISP_ACTIVE) begin
			REFRESH_ADDRESS <= REFRESH_ADDRESS + ADDR_STEP;
		end
	end

	// vertical sync follows its request; in the odd field both edges wait
	// for the mid-line point, so the field's lines sit between the others
	always_comb begin
		vs_next = vs_reg;
		unique case (vs_reg)
			VS_LOW: begin
				if (VSYNC_REQ && !vsync_req_d_reg) begin
					vs_next = (interlaced && FIELD_ODD) ? VS_PEND_ON :
						VS_HIGH;
				end
			end
			VS_PEND_ON: begin
				if (HALF_LINE) begin
					vs_next = VS_HIGH;
				end
			end
			VS_HIGH: begin
				if (!VSYNC_REQ && vsync_req_d_reg) begin
					vs_next = (interlaced && FIELD_ODD) ? VS_PEND_OFF :
						VS_LOW;
				end
			end
			VS_PEND_OFF: begin
				if (HALF_LINE) begin
					vs_next = VS_LOW;
				end
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			vs_reg <= VS_LOW;
			vsync_req_d_reg <= 1'b0;
			VERTICAL_SYNC <= 1'b0;
		end else begin
			vs_reg <= vs_next;
			vsync_req_d_reg <= VSYNC_REQ;
			VERTICAL_SYNC <= (vs_next == VS_HIGH) ||
				(vs_next == VS_PEND_OFF);
		end
	end

	// blink phase from the field counter
	ciar_blink_div #(
		.CNT_W(FIELD_CNT_W)
	) u_blink (
		.clk(CLK),
		.reset_n(RESET_N),
		.field_tick(FRAME_START),
		.field_count(field_count)
	);

	always_comb begin
		blink_on = 1'b0;
		unique case (cur_mode)
			CUR_STEADY: begin
				blink_on = 1'b1;
			end
			CUR_OFF: begin
				blink_on = 1'b0;
			end
			CUR_BLINK16: begin
				blink_on = field_count[BLINK16_BIT];
			end
			CUR_BLINK32: begin
				blink_on = field_count[BLINK32_BIT];
			end
		endcase
	end

	// an end line above max in sync and video mode covers every line of
	// both fields; the parity of start and end is the host's business
	assign cursor_span = (video_il &&
		(cursor_last_line_reg > max_scan_line_reg)) ? 1'b1 :
		in_span(ROW_ADDRESS,
		cursor_first_line_and_blink_reg[CUR_LINE_LSB +: ROW_W],
		cursor_last_line_reg);
	assign cursor_hit = DISP_ACTIVE && (REFRESH_ADDRESS == cursor_addr) &&
		cursor_span && blink_on;

	// cursor lags the address by one clock, matching registered video
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CURSOR_OUT <= 1'b0;
		end else begin
			CURSOR_OUT <= cursor_hit;
		end
	end

	// light pen capture; the pin is asynchronous
	ciar_pen_capture #(
		.ADDR_W(ADDR_W)
	) u_pen (
		.clk(CLK),
		.reset_n(RESET_N),
		.pen_strobe_in(PEN_STROBE_IN),
		.refresh_address(REFRESH_ADDRESS),
		.captured(pen_addr)
	);
endmodule

// [verilog/ciar_pkg.sv]
// shared constants and types for the interlace, cursor and address block
package ciar_pkg;
	localparam int ADDR_W = 14;
	localparam int ROW_W = 5;
	localparam int DATA_W = 8;
	localparam int IDX_W = 5;
	localparam int HIGH_W = 6;
	localparam int FIELD_CNT_W = 5;

	// register indexes on the register select port
	localparam logic [IDX_W-1:0] IDX_INTERLACE = 5'h08;
	localparam logic [IDX_W-1:0] IDX_MAX_SCAN = 5'h09;
	localparam logic [IDX_W-1:0] IDX_CUR_FIRST = 5'h0a;
	localparam logic [IDX_W-1:0] IDX_CUR_LAST = 5'h0b;
	localparam logic [IDX_W-1:0] IDX_START_HI = 5'h0c;
	localparam logic [IDX_W-1:0] IDX_START_LO = 5'h0d;
	localparam logic [IDX_W-1:0] IDX_CUR_POS_HI = 5'h0e;
	localparam logic [IDX_W-1:0] IDX_CUR_POS_LO = 5'h0f;
	localparam logic [IDX_W-1:0] IDX_PEN_HI = 5'h10;
	localparam logic [IDX_W-1:0] IDX_PEN_LO = 5'h11;

	// field positions
	localparam int MODE_LSB = 0;
	localparam int MODE_W = 2;
	localparam int CUR_LINE_LSB = 0;
	localparam int CUR_MODE_LSB = 5;
	localparam int CUR_MODE_W = 2;
	localparam int CUR_FIRST_W = 7;
	localparam int BLINK16_BIT = 3;
	localparam int BLINK32_BIT = 4;

	// reset values
	localparam logic [MODE_W-1:0] RST_MODE = 2'h0;
	localparam logic [ROW_W-1:0] RST_ROW = 5'h00;
	localparam logic [CUR_FIRST_W-1:0] RST_CUR_FIRST = 7'h00;
	localparam logic [ADDR_W-1:0] RST_ADDR = 14'h0000;
	localparam logic [DATA_W-1:0] RST_DATA = 8'h00;

	// row and refresh address counter steps
	localparam logic [ROW_W-1:0] ROW_STEP_ONE = 5'h01;
	localparam logic [ROW_W-1:0] ROW_STEP_TWO = 5'h02;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 14'h0001;

	typedef enum logic [1:0] {
		SCAN_NORMAL = 2'b00,
		SCAN_ISYNC = 2'b01,
		SCAN_UNUSED = 2'b10,
		SCAN_IVIDEO = 2'b11
	} ciar_scan_t;

	typedef enum logic [1:0] {
		CUR_STEADY = 2'b00,
		CUR_OFF = 2'b01,
		CUR_BLINK16 = 2'b10,
		CUR_BLINK32 = 2'b11
	} ciar_cur_t;

	typedef enum logic [1:0] {
		VS_LOW = 2'b00,
		VS_HIGH = 2'b01,
		VS_PEND_ON = 2'b10,
		VS_PEND_OFF = 2'b11
	} ciar_vs_t;
endpackage

// [verilog/ciar_blink_div.sv]
// field counter that divides the field rate for cursor blink
`timescale 1ns/1ps
module ciar_blink_div #(
	parameter int CNT_W = 5
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic field_tick,
	output logic [CNT_W-1:0] field_count
);
	// free running, so both blink rates stay in step with each other
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			field_count <= '0;
		end else if (field_tick) begin
			field_count <= field_count + 1'b1;
		end
	end
endmodule

// [verilog/ciar_pen_capture.sv]
// light pen strobe synchroniser and refresh address capture
`timescale 1ns/1ps
module ciar_pen_capture #(
	parameter int ADDR_W = 14
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic pen_strobe_in,
	input wire logic [ADDR_W-1:0] refresh_address,
	output logic [ADDR_W-1:0] captured
);
	logic sync1_reg;
	logic sync2_reg;
	logic sync3_reg;

	// two flops against metastability, a third for the edge detect
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
		end else begin
			sync1_reg <= pen_strobe_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// address lags the strobe by the sync delay; software corrects it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			captured <= '0;
		end else if (sync2_reg && !sync3_reg) begin
			captured <= refresh_address;
		end
	end
endmodule

// [sim/ciar_monitor.sv]
// assertion checker on the ports of the interlace, cursor and address block
`timescale 1ns/1ps
module ciar_monitor
	import ciar_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic CHAR_TICK,
	input wire logic DISP_ACTIVE,
	input wire logic LINE_END,
	input wire logic HALF_LINE,
	input wire logic FRAME_START,
	input wire logic VSYNC_REQ,
	input wire logic PEN_STROBE_IN,
	input wire logic VERTICAL_SYNC,
	input wire logic CURSOR_OUT,
	input wire logic FIELD_ODD,
	input wire logic [ciar_pkg::IDX_W-1:0] REG_ADDR,
	input wire logic [ciar_pkg::DATA_W-1:0] REG_WDATA,
	input wire logic [ciar_pkg::DATA_W-1:0] REG_RDATA,
	input wire logic [ciar_pkg::ADDR_W-1:0] REFRESH_ADDRESS,
	input wire logic [ciar_pkg::ROW_W-1:0] ROW_ADDRESS
);
	logic [1:0] mode_reg, cmode_reg;
	logic [ROW_W-1:0] max_reg;
	logic [ADDR_W-1:0] start_reg;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// shadow of the programmed values; a write lands on its strobe edge
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			mode_reg <= 2'h0;
			cmode_reg <= 2'h0;
			max_reg <= 5'h00;
			start_reg <= 14'h0000;
		end else if (REG_WR) begin
			case (REG_ADDR)
			IDX_INTERLACE: mode_reg <= REG_WDATA[1:0];
			IDX_CUR_FIRST: cmode_reg <= REG_WDATA[6:5];
			IDX_MAX_SCAN: max_reg <= REG_WDATA[4:0];
			IDX_START_HI: start_reg[13:8] <= REG_WDATA[5:0];
			IDX_START_LO: start_reg[7:0] <= REG_WDATA;
			default: ;
			endcase
		end
	end
	sequence s_odd_req;
		$rose(VSYNC_REQ) && FIELD_ODD && mode_reg[0];
	endsequence
	sequence s_pos_wr;
		REG_WR && REG_ADDR == IDX_CUR_POS_LO;
	endsequence
	sequence s_pos_rd;
		REG_RD && !REG_WR && REG_ADDR == IDX_CUR_POS_LO;
	endsequence
	property p_start;
		FRAME_START |=> REFRESH_ADDRESS == $past(start_reg);
	endproperty
	a_start: assert property (p_start) else $error("start lost");
	property p_fnorm;
		FRAME_START && !mode_reg[0] |=> !FIELD_ODD;
	endproperty
	a_fnorm: assert property (p_fnorm) else $error("odd field");
	property p_ftog;
		FRAME_START && mode_reg[0] |=> FIELD_ODD != $past(FIELD_ODD);
	endproperty
	a_ftog: assert property (p_ftog) else $error("no toggle");
	property p_wrap;
		LINE_END && !FRAME_START && mode_reg != 2'h3 &&
			ROW_ADDRESS == max_reg |=> ROW_ADDRESS == 5'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap");
	// the wide compare avoids a false failure when the row sum overflows
	property p_step2;
		LINE_END && !FRAME_START && mode_reg == 2'h3 &&
			{1'b0, ROW_ADDRESS} + 6'h02 <= {1'b0, max_reg}
			|=> ROW_ADDRESS == $past(ROW_ADDRESS) + 5'h02;
	endproperty
	a_step2: assert property (p_step2) else $error("bad step");
	property p_vs_odd;
		s_odd_req |=> !VERTICAL_SYNC;
	endproperty
	a_vs_odd: assert property (p_vs_odd) else $error("early sync");
	property p_cur_off;
		cmode_reg == 2'h1 |=> !CURSOR_OUT;
	endproperty
	a_cur_off: assert property (p_cur_off) else $error("cursor on");
	property p_wr_rd;
		s_pos_wr ##1 s_pos_rd |=> REG_RDATA == $past(REG_WDATA, 2);
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("bad readback");
endmodule

// [sim/ciar_raster_model.sv]
// raster timing source standing in for the horizontal counter
`timescale 1ns/1ps
module ciar_raster_model #(
	parameter int HT = 7,
	parameter int HD = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic run,
	output logic char_tick,
	output logic disp_active,
	output logic line_end,
	output logic half_line
);
	logic act_reg;
	int pos_reg;
	// one character per clock; an odd HT gives an even count per line
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			act_reg <= 1'b0;
			pos_reg <= 0;
		end else begin
			act_reg <= run;
			pos_reg <= (!act_reg || pos_reg == HT) ? 0 : pos_reg + 1;
		end
	end
	// strobes stay quiet while stopped, so no stray line end gets through
	assign char_tick = act_reg;
	assign disp_active = act_reg && pos_reg < HD;
	assign line_end = act_reg && pos_reg == HT;
	assign half_line = act_reg && pos_reg == (HT + 1) / 2;
endmodule

// [sim/ciar_top_tb.sv]
// self-checking bench for the interlace, cursor and address block
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module ciar_top_tb;
	import ciar_pkg::*;
	logic clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0, fs = 1'b0;
	logic vreq = 1'b0, pen = 1'b0, run = 1'b0, fexp = 1'b0;
	logic tick, disp, lend, half, vs, cur, fodd;
	logic [IDX_W-1:0] addr = 5'h00;
	logic [DATA_W-1:0] wdata = 8'h00, rdata;
	logic [ADDR_W-1:0] ra, st = 14'h0000, pexp = 14'h0000;
	logic [ROW_W-1:0] row;
	logic [2:0] kq[$];
	logic [ADDR_W-1:0] q[$];
	int err_count = 0, compares = 0, fs_n = 0, ncur = 0, nbase = 0;
	ciar_top u_dut (.CLK(clk), .RESET_N(reset_n), .REG_ADDR(addr),
		.REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
		.CHAR_TICK(tick), .DISP_ACTIVE(disp), .LINE_END(lend),
		.HALF_LINE(half), .FRAME_START(fs), .VSYNC_REQ(vreq),
		.PEN_STROBE_IN(pen), .REFRESH_ADDRESS(ra), .ROW_ADDRESS(row),
		.VERTICAL_SYNC(vs), .CURSOR_OUT(cur), .FIELD_ODD(fodd));
	ciar_raster_model u_ras (.clk(clk), .reset_n(reset_n), .run(run),
		.char_tick(tick), .disp_active(disp), .line_end(lend),
		.half_line(half));
	initial forever #10 clk = ~clk;
	// the oldest note is judged against the output that it names
	always @(posedge clk) begin
		ncur <= ncur + int'(cur === 1'b1);
		if (q.size() > 0) begin
			case (kq[0])
			3'h1: `CHK(rdata, q[0][DATA_W-1:0])
			3'h2: `CHK(ra, q[0])
			3'h3: `CHK(row, q[0][ROW_W-1:0])
			3'h4: `CHK(fodd, q[0][0])
			3'h5: `CHK(vs, q[0][0])
			default: `CHK(ncur - nbase, int'(q[0]))
			endcase
			void'(q.pop_front());
			void'(kq.pop_front());
		end
	end
	// the write strobe stays up across back to back writes and drops here
	task automatic cyc(input int n);
		wr = 1'b0;
		repeat (n) @(negedge clk);
	endtask
	task automatic note(input logic [2:0] k, input logic [ADDR_W-1:0] e);
		q.push_back(e);
		kq.push_back(k);
		cyc(1);
	endtask
	task automatic wreg(input logic [IDX_W-1:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
	endtask
	task automatic rreg(input logic [IDX_W-1:0] a, input logic [7:0] e);
		addr = a;
		wr = 1'b0;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		note(3'h1, ADDR_W'(e));
	endtask
	task automatic fstart();
		fs = 1'b1;
		cyc(1);
		fs = 1'b0;
		fs_n++;
		note(3'h2, st);
	endtask
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// bounded wait: 0 line end, 1 sync high, 2 sync low
	task automatic hold(input int w);
		for (int i = 0; i < 40; i++) begin
			cyc(1);
			if ((w == 0 && lend === 1'b1) || (w == 1 && vs === 1'b1) ||
				(w == 2 && vs === 1'b0))
				return;
		end
		err_count++;
		$display("[FAIL] %0t wait ran out", $time);
		wrap_up();
	endtask
	initial begin
		void'($urandom(41465));
		cyc(4);
		reset_n = 1'b1;
		// every mapped place reads zero after reset, unmapped index 1f too
		for (int i = 8; i < 18; i++)
			rreg(IDX_W'(i), 8'h00);
		rreg(5'h1f, 8'h00);
		st = ADDR_W'($urandom);
		wreg(IDX_CUR_POS_HI, {2'h3, st[13:8]});
		wreg(IDX_CUR_POS_LO, st[7:0]);
		rreg(IDX_CUR_POS_LO, st[7:0]);
		rreg(IDX_CUR_POS_HI, {2'h0, st[13:8]});
		wreg(IDX_MAX_SCAN, 8'h01);
		rreg(IDX_MAX_SCAN, 8'h00);
		$display("test registers done");
		// two scan lines per row: return to row base, then wrap
		pexp = st + 14'h0001;
		wreg(IDX_START_HI, {2'h0, st[13:8]});
		wreg(IDX_START_LO, st[7:0]);
		wreg(IDX_CUR_POS_HI, {2'h0, pexp[13:8]});
		wreg(IDX_CUR_POS_LO, pexp[7:0]);
		fstart();
		note(3'h4, 14'h0000);
		run = 1'b1;
		hold(0);
		cyc(1);
		note(3'h2, st);
		note(3'h3, 14'h0001);
		hold(0);
		cyc(1);
		note(3'h2, st + 14'h0004);
		note(3'h3, 14'h0000);
		run = 1'b0;
		$display("test raster done");
		// cursor on line zero only, equal parity of first and last
		for (int m = 0; m < 4; m++) begin
			wreg(IDX_CUR_FIRST, {1'b0, m[1:0], 5'h00});
			fstart();
			nbase = ncur;
			run = 1'b1;
			hold(0);
			hold(0);
			run = 1'b0;
			note(3'h6, ADDR_W'(m == 0 ? 1 : m == 1 ? 0 :
				m == 2 ? fs_n[3] : fs_n[4]));
		end
		$display("test cursor done");
		wreg(IDX_MAX_SCAN, 8'h03);
		for (int m = 0; m < 4; m++) begin
			wreg(IDX_INTERLACE, 8'(m));
			repeat (2) begin
				fstart();
				fexp = m[0] & ~fexp;
				note(3'h4, ADDR_W'(fexp));
				note(3'h3, ADDR_W'(m == 3 && fexp));
				vreq = 1'b1;
				cyc(1);
				note(3'h5, ADDR_W'(!fexp));
				run = 1'b1;
				hold(1);
				vreq = 1'b0;
				hold(2);
				run = 1'b0;
			end
		end
		// end line above max: every visited line of the field shows it
		wreg(IDX_CUR_FIRST, 8'h04);
		wreg(IDX_CUR_LAST, 8'h1f);
		fstart();
		nbase = ncur;
		run = 1'b1;
		hold(0);
		hold(0);
		run = 1'b0;
		note(3'h6, 14'h0002);
		$display("test interlace done");
		// pen: the write is ignored, capture lands three edges later
		run = 1'b1;
		wreg(IDX_PEN_LO, ~st[7:0]);
		cyc(3);
		pen = 1'b1;
		cyc(2);
		pexp = ra;
		cyc(2);
		pen = 1'b0;
		run = 1'b0;
		rreg(IDX_PEN_HI, {2'h0, pexp[13:8]});
		rreg(IDX_PEN_LO, pexp[7:0]);
		$display("test pen done");
		wrap_up();
	end
endmodule
bind ciar_top ciar_monitor u_mon (.CLK(CLK), .RESET_N(RESET_N),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .CHAR_TICK(CHAR_TICK),
	.DISP_ACTIVE(DISP_ACTIVE), .LINE_END(LINE_END), .HALF_LINE(HALF_LINE),
	.FRAME_START(FRAME_START), .VSYNC_REQ(VSYNC_REQ),
	.PEN_STROBE_IN(PEN_STROBE_IN), .VERTICAL_SYNC(VERTICAL_SYNC),
	.CURSOR_OUT(CURSOR_OUT), .FIELD_ODD(FIELD_ODD), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.REFRESH_ADDRESS(REFRESH_ADDRESS), .ROW_ADDRESS(ROW_ADDRESS));
